// *** rtl/bbc_pkg.sv ***
/*
 Constants for the backlight brightness control block.
 Assumes a 40 MHz core clock and a byte-addressed Avalon-MM view.
*/
package bbc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h02;
  localparam logic [5:0] IDX_RAMP = 6'h03;
  localparam logic [5:0] IDX_BRT_LO = 6'h04;
  localparam logic [5:0] IDX_BRT_HI = 6'h05;
  localparam logic [5:0] IDX_ENABLE = 6'h08;
  localparam logic [5:0] IDX_FDBK = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h14;
  // Field positions
  localparam int CTRL_PWM_EN = 0;
  localparam int CTRL_PWM_RAMP = 1;
  localparam int CTRL_LINEAR = 3;
  localparam int RAMP_LSB = 3;
  localparam int EN_BL = 4;
  localparam int FDBK_LSB = 3;
  localparam int STAT_CODE_LSB = 16;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h08;
  localparam logic [3:0] RST_RAMP = 4'h0;
  localparam logic [2:0] RST_BRT_LO = 3'h7;
  localparam logic [7:0] RST_BRT_HI = 8'hff;
  // Linear map in 10 nA units: 45.37 uA + 14.63 uA per code
  localparam logic [21:0] LIN_OFS = 22'd4537;
  localparam logic [21:0] LIN_SLOPE = 22'd1463;
  // Exponential map: 60 uA start, Q8 accumulator
  localparam logic [31:0] EXP_BASE = 32'd1536000;
  localparam int EXP_FRAC = 8;
  localparam int K_FRAC = 16;
  // Ramp is cut into 2 to this power (256) equal steps
  localparam int RAMP_STEP_BITS = 8;
  localparam int MS_PER_S = 1000;
  // Operating states
  typedef enum logic [1:0] {
    BBC_SHUTDOWN,
    BBC_STANDBY,
    BBC_ACTIVE
  } bbc_mode_e;
  typedef enum logic {
    BBC_MAP_IDLE,
    BBC_MAP_RUN
  } bbc_map_e;
endpackage : bbc_pkg

// *** rtl/bbc_top.sv ***
/*
 Backlight brightness control: register file, duty sampler,
 ramper, code mapping and state decode in one module.
 Assumes an Avalon-MM master and a pulse input synchronous to clk.
*/
// The implementer's own choices: the Avalon-MM register port and the address map.
// How it works
// - Enable input low holds block in reset
// - Standby when backlight off or code,sinks zero
// - Standby keeps registers and accepts writes
// - Both feedback bits set: boost off, sinks on
// - Mapping bit zero exponential, one linear
// - Linear current 45.37 plus 14.63 per code
// - Exponential current 60 times 1.003040572 power
// - Code zero gives zero current
// - Mapped code is register or register times duty
// - Duty input off ignores pulse input
// - Code is high byte over three low bits
// - Target updates only on high byte write
// - Register-only ramp spans set-point changes
// - Linear with duty uses code times duty
// - Exponential with duty uses code times duty
// - Ramp-select bit decides ramping of duty changes
// - Ramp time 0 to 8000 ms, four bits
// - Same ramp time up and down
// - Ramp time fixed regardless of step size
// - Ramp-select zero multiplies after the ramper
// - Ramp-select one multiplies before the ramper
// - Duty enabled waits standby for nonzero duty
// - Reset defaults: off, linear, full scale
// - Enable low restores defaults, shuts down
`timescale 1ns/1ps
module bbc_top #(
  parameter int CLK_KHZ = 40000, // Core clock rate, lower for sim
  parameter int PWM_WIN_BITS = 16 // Duty sample window, log2 cycles
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Device pins
  input wire logic master_enable_n,
  input wire logic pwm_in,
  // Power stage controls
  output logic boost_on,
  output logic [1:0] sink_en,
  output logic [21:0] sink_current,
  output logic [1:0] op_mode
);
  // Full state of the block
  typedef struct packed {
    logic wait_r;
    logic [31:0] rdata;
    logic pwm_en;
    logic pwm_ramp;
    logic linear;
    logic [3:0] ramp_duration_field;
    logic [2:0] brt_lo;
    logic [7:0] brt_hi;
    logic [10:0] brt_tgt; // Set-point, latched on the high byte write
    logic backlight_on;
    logic [1:0] sink_sel;
    logic [1:0] sink_feedback_off;
    logic pwm_q;
    logic [PWM_WIN_BITS-1:0] win_cnt;
    logic [PWM_WIN_BITS:0] hi_cnt;
    logic [11:0] duty;
    logic [10:0] r_start;
    logic [10:0] r_tgt;
    logic [10:0] r_cur;
    logic [bbc_pkg::RAMP_STEP_BITS:0] r_step;
    logic [31:0] r_tick;
    bbc_pkg::bbc_map_e map_st;
    logic [10:0] m_code;
    logic m_lin;
    logic [3:0] m_bit;
    logic [31:0] m_acc;
    logic [21:0] m_exp; // Last exponential result, held while idle
    logic boost;
    logic [1:0] sinks;
    logic [21:0] current;
    bbc_pkg::bbc_mode_e mode;
  } bbc_state_s;

  bbc_state_s st_ff; // Registered state
  bbc_state_s nxt_st; // Next state

  // Ramp time in ms per field value
  function automatic logic [31:0] bbc_ramp_ms(input logic [3:0] f);
    logic [31:0] ms;
    ms = 32'h0;
    unique case (f)
      4'h0: ms = 32'd0;
      4'h1: ms = 32'd1;
      4'h2: ms = 32'd2;
      4'h3: ms = 32'd5;
      4'h4: ms = 32'd10;
      4'h5: ms = 32'd20;
      4'h6: ms = 32'd50;
      4'h7: ms = 32'd100;
      4'h8: ms = 32'd250;
      4'h9: ms = 32'd500;
      4'ha: ms = 32'd750;
      4'hb: ms = 32'd1000;
      4'hc: ms = 32'd2000;
      4'hd: ms = 32'd4000;
      4'he: ms = 32'd6000;
      4'hf: ms = 32'd8000;
    endcase
    return ms;
  endfunction : bbc_ramp_ms

  // Q16 factor 1.003040572 to the power 2^k
  function automatic logic [21:0] bbc_exp_k(input logic [3:0] k);
    logic [21:0] c;
    c = 22'h0;
    unique case (k)
      4'd0: c = 22'd65735;
      4'd1: c = 22'd65935;
      4'd2: c = 22'd66337;
      4'd3: c = 22'd67147;
      4'd4: c = 22'd68798;
      4'd5: c = 22'd72223;
      4'd6: c = 22'd79591;
      4'd7: c = 22'd96660;
      4'd8: c = 22'd142566;
      4'd9: c = 22'd310135;
      default: c = 22'd1467658;
    endcase
    return c;
  endfunction : bbc_exp_k

  // Code times duty, truncated and clamped to 11 bits
  function automatic logic [10:0] bbc_scale(input logic [10:0] c,
                                            input logic [11:0] d);
    logic [22:0] p;
    p = {12'h0, c} * {11'h0, d};
    if (p[22:11] > 12'd2047)
      return 11'h7ff;
    return p[21:11];
  endfunction : bbc_scale

  // Whole-ramp cycle count; steps are spread over it by an accumulator
  localparam logic [31:0] CLK_KHZ_W = 32'(CLK_KHZ);
  localparam logic [31:0] RAMP_STEPS_W = 32'h1 << bbc_pkg::RAMP_STEP_BITS;
  localparam logic signed [21:0] RAMP_DIV = 22'sh1 << bbc_pkg::RAMP_STEP_BITS;
  logic [31:0] ramp_cyc; // Cycles in one whole ramp
  logic [10:0] brt_code; // Register code seen by the ramper
  logic [10:0] ramp_in; // Ramper input
  logic [10:0] final_code; // Code fed to the mapping
  logic [5:0] idx; // Word index of the access
  logic standby; // Decoded standby condition
  logic [53:0] prod; // Exponential step product
  logic signed [21:0] r_ofs; // Ramp offset from start

  // Ramp length in cycles; fits 32 bits up to 8000 ms at 40 MHz
  always_comb
  begin
    ramp_cyc = bbc_ramp_ms(st_ff.ramp_duration_field) * CLK_KHZ_W;
  end

  // Next state logic
  always_comb
  begin
    nxt_st = st_ff;
    idx = address[7:2];
    brt_code = st_ff.brt_tgt; // Latched set-point, not the live pair
    prod = 54'h0;
    r_ofs = 22'sh0;

    // Bus handshake: one wait cycle, then a single ready cycle
    nxt_st.wait_r = 1'b1;
    if ((read || write) && st_ff.wait_r)
      nxt_st.wait_r = 1'b0;
    if (read && st_ff.wait_r)
    begin
      nxt_st.rdata = 32'h0; // Unmapped reads give zero
      unique case (idx)
        bbc_pkg::IDX_CTRL:
          nxt_st.rdata = 32'({st_ff.linear, 1'b0, st_ff.pwm_ramp, st_ff.pwm_en});
        bbc_pkg::IDX_RAMP:
          nxt_st.rdata = 32'(st_ff.ramp_duration_field) << bbc_pkg::RAMP_LSB;
        bbc_pkg::IDX_BRT_LO:
          nxt_st.rdata = 32'(st_ff.brt_lo);
        bbc_pkg::IDX_BRT_HI:
          nxt_st.rdata = 32'(st_ff.brt_hi);
        bbc_pkg::IDX_ENABLE:
          nxt_st.rdata = (32'(st_ff.backlight_on) << bbc_pkg::EN_BL)
                         | 32'(st_ff.sink_sel);
        bbc_pkg::IDX_FDBK:
          nxt_st.rdata = 32'(st_ff.sink_feedback_off) << bbc_pkg::FDBK_LSB;
        bbc_pkg::IDX_STATUS:
          nxt_st.rdata = (32'(st_ff.m_code) << bbc_pkg::STAT_CODE_LSB)
                         | 32'(st_ff.mode);
        default:
          nxt_st.rdata = 32'h0;
      endcase
    end

    // Writes land at the edge where waitrequest is seen low
    if (write && !st_ff.wait_r && byteenable[0])
    begin
      unique case (idx)
        bbc_pkg::IDX_CTRL:
        begin
          nxt_st.pwm_en = writedata[bbc_pkg::CTRL_PWM_EN];
          nxt_st.pwm_ramp = writedata[bbc_pkg::CTRL_PWM_RAMP];
          nxt_st.linear = writedata[bbc_pkg::CTRL_LINEAR];
        end
        bbc_pkg::IDX_RAMP:
          nxt_st.ramp_duration_field = writedata[bbc_pkg::RAMP_LSB +: 4];
        bbc_pkg::IDX_BRT_LO:
          nxt_st.brt_lo = writedata[2:0];
        bbc_pkg::IDX_BRT_HI:
        begin
          nxt_st.brt_hi = writedata[7:0];
          // Only this write moves the set-point, so a lone low write waits
          nxt_st.brt_tgt = {writedata[7:0], st_ff.brt_lo};
        end
        bbc_pkg::IDX_ENABLE:
        begin
          nxt_st.backlight_on = writedata[bbc_pkg::EN_BL];
          nxt_st.sink_sel = writedata[1:0];
        end
        bbc_pkg::IDX_FDBK:
          nxt_st.sink_feedback_off = writedata[bbc_pkg::FDBK_LSB +: 2];
        default:
          nxt_st.pwm_q = st_ff.pwm_q; // Unmapped writes are dropped
      endcase
    end

    // Duty sampler: share of high cycles over a fixed window
    nxt_st.pwm_q = pwm_in;
    nxt_st.win_cnt = st_ff.win_cnt + 1'b1;
    nxt_st.hi_cnt = st_ff.hi_cnt + {{PWM_WIN_BITS{1'b0}}, st_ff.pwm_q};
    if (&st_ff.win_cnt)
    begin
      nxt_st.duty = 12'(nxt_st.hi_cnt >> (PWM_WIN_BITS - 11));
      nxt_st.hi_cnt = '0;
    end

    // Ramper input: product before the ramper only when ramp-select set
    if (st_ff.pwm_en && st_ff.pwm_ramp)
      ramp_in = bbc_scale(brt_code, st_ff.duty);
    else
      ramp_in = brt_code;

    // Ramper: fixed step count, so time is independent of size
    if (ramp_in != st_ff.r_tgt)
    begin
      // New set-point restarts from the present level
      nxt_st.r_start = st_ff.r_cur;
      nxt_st.r_tgt = ramp_in;
      nxt_st.r_step = '0;
      nxt_st.r_tick = 32'h0;
    end
    else if (st_ff.r_cur != st_ff.r_tgt)
    begin
      // Accumulator gains the step count each cycle and steps on each wrap,
      // so all steps together span ramp_cyc cycles; a ramp shorter than
      // the step count takes one step per cycle instead
      nxt_st.r_tick = st_ff.r_tick + RAMP_STEPS_W;
      if (st_ff.r_tick + RAMP_STEPS_W >= ramp_cyc)
      begin
        nxt_st.r_tick = 32'h0;
        if (ramp_cyc > RAMP_STEPS_W)
          nxt_st.r_tick = st_ff.r_tick + RAMP_STEPS_W - ramp_cyc;
        nxt_st.r_step = st_ff.r_step + 1'b1;
        r_ofs = (22'(signed'({1'b0, st_ff.r_tgt})) -
                 22'(signed'({1'b0, st_ff.r_start}))) *
                22'(signed'({1'b0, nxt_st.r_step}));
        // Division truncates toward zero, so falls pace like rises
        nxt_st.r_cur = 11'(22'(signed'({1'b0, st_ff.r_start})) +
                           (r_ofs / RAMP_DIV));
        if (st_ff.ramp_duration_field == 4'h0)
          nxt_st.r_cur = st_ff.r_tgt; // Zero time jumps at once
      end
    end

    // Duty applied after the ramper when ramp-select clear
    if (st_ff.pwm_en && !st_ff.pwm_ramp)
      final_code = bbc_scale(st_ff.r_cur, st_ff.duty);
    else
      final_code = st_ff.r_cur;

    // Mapping engine
    unique case (st_ff.map_st)
      bbc_pkg::BBC_MAP_IDLE:
      begin
        if (final_code != st_ff.m_code || st_ff.linear != st_ff.m_lin)
        begin
          nxt_st.m_code = final_code;
          nxt_st.m_lin = st_ff.linear;
          nxt_st.m_bit = 4'h0;
          nxt_st.m_acc = bbc_pkg::EXP_BASE;
          if (!st_ff.linear)
            nxt_st.map_st = bbc_pkg::BBC_MAP_RUN;
        end
        if (st_ff.m_code == 11'h0)
          nxt_st.current = 22'h0;
        else if (st_ff.m_lin)
          nxt_st.current = bbc_pkg::LIN_OFS +
                           22'(bbc_pkg::LIN_SLOPE * 22'(st_ff.m_code));
        else
          nxt_st.current = st_ff.m_exp; // Restores current after standby
      end
      bbc_pkg::BBC_MAP_RUN:
      begin
        // Square-and-multiply over the eleven code bits
        prod = {22'h0, st_ff.m_acc} * {32'h0, bbc_exp_k(st_ff.m_bit)};
        if (st_ff.m_code[st_ff.m_bit])
          nxt_st.m_acc = 32'(prod >> bbc_pkg::K_FRAC);
        nxt_st.m_bit = st_ff.m_bit + 4'h1;
        if (st_ff.m_bit == 4'd10)
        begin
          nxt_st.map_st = bbc_pkg::BBC_MAP_IDLE;
          nxt_st.current = 22'(nxt_st.m_acc >> bbc_pkg::EXP_FRAC);
          nxt_st.m_exp = 22'(nxt_st.m_acc >> bbc_pkg::EXP_FRAC);
          if (st_ff.m_code == 11'h0)
            nxt_st.current = 22'h0;
        end
      end
    endcase

    // Operating state decode
    standby = !st_ff.backlight_on
              || brt_code == 11'h0 || st_ff.sink_sel == 2'b00
              || (st_ff.pwm_en && st_ff.duty == 12'h0);
    nxt_st.mode = standby ? bbc_pkg::BBC_STANDBY : bbc_pkg::BBC_ACTIVE;
    nxt_st.sinks = standby ? 2'b00 : st_ff.sink_sel;
    nxt_st.boost = !standby && st_ff.sink_feedback_off != 2'b11;
    if (standby)
      nxt_st.current = 22'h0;

    // Enable low: shut down, restore defaults, ignore the bus
    if (!master_enable_n)
    begin
      nxt_st = '0;
      nxt_st.wait_r = 1'b1;
      nxt_st.linear = 1'b1;
      nxt_st.brt_lo = bbc_pkg::RST_BRT_LO;
      nxt_st.brt_hi = bbc_pkg::RST_BRT_HI;
      nxt_st.brt_tgt = {bbc_pkg::RST_BRT_HI, bbc_pkg::RST_BRT_LO};
      nxt_st.r_tgt = 11'h7ff;
      nxt_st.r_cur = 11'h7ff;
      nxt_st.mode = bbc_pkg::BBC_SHUTDOWN;
      // Still answer so a master never hangs; data is dropped
      if ((read || write) && st_ff.wait_r)
        nxt_st.wait_r = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_ff <= '0;
      st_ff.wait_r <= 1'b1;
      st_ff.linear <= bbc_pkg::RST_CTRL[bbc_pkg::CTRL_LINEAR];
      st_ff.ramp_duration_field <= bbc_pkg::RST_RAMP;
      st_ff.brt_lo <= bbc_pkg::RST_BRT_LO;
      st_ff.brt_hi <= bbc_pkg::RST_BRT_HI;
      st_ff.brt_tgt <= {bbc_pkg::RST_BRT_HI, bbc_pkg::RST_BRT_LO};
      st_ff.r_tgt <= 11'h7ff;
      st_ff.r_cur <= 11'h7ff;
      st_ff.m_lin <= 1'b1;
      st_ff.mode <= bbc_pkg::BBC_SHUTDOWN;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs straight from the state register
  assign readdata = st_ff.rdata;
  assign waitrequest = st_ff.wait_r;
  assign boost_on = st_ff.boost;
  assign sink_en = st_ff.sinks;
  assign sink_current = st_ff.current;
  assign op_mode = st_ff.mode;
endmodule : bbc_top

// *** test/bbc_checker.sv ***
/*
 Checker for bbc_top: bus handshake and power-state relations.
 Assumes one clock with sync active-low reset; bound below.
*/
`timescale 1ns/1ps
module bbc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Pins and power outputs
  input wire logic master_enable_n,
  input wire logic boost_on,
  input wire logic [1:0] sink_en,
  input wire logic [21:0] sink_current,
  input wire logic [1:0] op_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Request taken while the slave waits
  sequence s_take;
    (read || write) && waitrequest;
  endsequence
  // Everything dark in shutdown
  sequence s_dark;
    op_mode == bbc_pkg::BBC_SHUTDOWN && !boost_on && sink_en == 2'h0 && sink_current == 22'h0;
  endsequence
  chk_answer_next:
    assert property (s_take |=> !waitrequest) else $error("answer late");
  chk_wait_pulse:
    assert property (!waitrequest |=> waitrequest) else $error("answer too long");
  chk_no_spurious:
    assert property (!(read || write) && waitrequest |=> waitrequest) else $error("stray answer");
  chk_shut_dark:
    assert property (!master_enable_n |=> s_dark) else $error("not dark in shutdown");
  chk_read_off:
    assert property (s_take ##0 (read && !master_enable_n) |=> readdata == 32'h0)
      else $error("read in shutdown");
  chk_leave_shut:
    assert property (!master_enable_n ##1 master_enable_n [*3] |-> op_mode == bbc_pkg::BBC_STANDBY)
      else $error("no standby after enable");
  chk_standby_dark:
    assert property (op_mode == bbc_pkg::BBC_STANDBY |-> !boost_on && sink_en == 2'h0)
      else $error("power on in standby");
  chk_boost_sinks:
    assert property (boost_on |-> sink_en != 2'h0 && op_mode == bbc_pkg::BBC_ACTIVE)
      else $error("boost without sinks");
endmodule : bbc_checker
bind bbc_top bbc_checker u_chk (.clk(clk), .rst_b(rst_b), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .master_enable_n(master_enable_n),
  .boost_on(boost_on), .sink_en(sink_en), .sink_current(sink_current), .op_mode(op_mode));

// *** test/bbc_pwm_src.sv ***
/*
 Duty source for the pulse pin: free-running 256-cycle frame.
 Assumes the bench sets high_cnt; zero holds the pin low.
*/
`timescale 1ns/1ps
module bbc_pwm_src (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // High cycles per frame
  input wire logic [7:0] high_cnt,
  // Pin
  output logic pwm_out
);
  logic [7:0] cnt_ff; // Frame position
  // Frame of 256 divides the sample window, so duty is exact
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
  // High for the first high_cnt cycles
  assign pwm_out = (cnt_ff < high_cnt);
endmodule : bbc_pwm_src

// *** test/testbench.sv ***
/*
 Self-checking bench for bbc_top: registers, modes, mapping, ramp, duty.
 Assumes CLK_KHZ 40 (1 ms = 40 cycles) and a 2048-cycle duty window.
*/
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic master_enable_n = 1'b1;
  logic pwm_in;
  logic [7:0] high_cnt = 8'h00;
  logic boost_on;
  logic [1:0] sink_en;
  logic [21:0] sink_current;
  logic [1:0] op_mode;
  logic [31:0] q; // Last read data
  logic [10:0] c;
  integer mismatches = 0;
  integer total_checks = 0;
  integer seed = 44062;
  integer i, s, m;
  real e;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  bbc_top #(.CLK_KHZ(40), .PWM_WIN_BITS(11)) dut (.clk(clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .byteenable(4'hf),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .master_enable_n(master_enable_n), .pwm_in(pwm_in), .boost_on(boost_on),
    .sink_en(sink_en), .sink_current(sink_current), .op_mode(op_mode));
  bbc_pwm_src src (.clk(clk), .rst_b(rst_b), .high_cnt(high_cnt), .pwm_out(pwm_in));
  task results;
  begin
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask : results
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask : check
  // One bus cycle; request held until waitrequest is sampled low at a
  // rising edge, read data taken at that edge, released right after it
  task bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    integer n;
  begin
    @(posedge clk);
    address <= {idx, 2'b00};
    write <= w;
    read <= !w;
    writedata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0)
    begin
      mismatches++;
      results();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  end
  endtask : bus
  // Low bits first, then high byte
  task setc(input logic [10:0] k);
  begin
    bus(1'b1, bbc_pkg::IDX_BRT_LO, {5'h0, k[2:0]});
    bus(1'b1, bbc_pkg::IDX_BRT_HI, k[10:3]);
  end
  endtask : setc
  task wt(input integer n);
  begin
    repeat (n) @(negedge clk);
  end
  endtask : wt
  // Code fed to the mapping, from the status word
  task code(input logic [10:0] k);
  begin
    bus(1'b0, bbc_pkg::IDX_STATUS, 8'h0);
    check("code", {21'h0, q[26:16]}, {21'h0, k});
  end
  endtask : code
  function automatic logic [21:0] lin(input logic [10:0] k);
    lin = (k == 11'h0) ? 22'h0 : 22'(4537 + 1463 * k);
  endfunction : lin
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, bbc_pkg::IDX_CTRL, 8'h0);
    check("ctrl", q, 32'h08);
    bus(1'b0, bbc_pkg::IDX_BRT_HI, 8'h0);
    check("brt_hi", q, 32'hff);
    bus(1'b0, bbc_pkg::IDX_ENABLE, 8'h0);
    check("enable", q, 32'h0);
    bus(1'b0, 6'h3f, 8'h0);
    check("unmapped", q, 32'h0);
    bus(1'b1, bbc_pkg::IDX_ENABLE, 8'h03);
    wt(4);
    check("mode_off", op_mode, 32'h1);
    bus(1'b0, bbc_pkg::IDX_ENABLE, 8'h0);
    check("kept", q, 32'h03);
    bus(1'b1, bbc_pkg::IDX_ENABLE, 8'h13);
    wt(6);
    check("full", sink_current, lin(11'h7ff));
    check("sinks", sink_en, 32'h3);
    for (i = 0; i < 6; i++)
    begin
      c = (i == 0) ? 11'h0 : (i == 1) ? 11'h1 : (i == 2) ? 11'h7ff : 11'($random(seed));
      setc(c);
      wt(6);
      check("lin", sink_current, lin(c));
      check("mode", op_mode, (c == 11'h0) ? 32'h1 : 32'h2);
    end
    setc(11'h400);
    bus(1'b1, bbc_pkg::IDX_BRT_LO, 8'h05);
    wt(6);
    code(11'h400);
    bus(1'b1, bbc_pkg::IDX_BRT_HI, 8'h80);
    wt(6);
    code(11'h405);
    bus(1'b1, bbc_pkg::IDX_FDBK, 8'h18);
    wt(6);
    check("boost", boost_on, 32'h0);
    check("fb_sinks", sink_en, 32'h3);
    bus(1'b1, bbc_pkg::IDX_FDBK, 8'h00);
    bus(1'b1, bbc_pkg::IDX_CTRL, 8'h00);
    for (i = 0; i < 3; i++)
    begin
      c = 11'(i * 1023 + 1);
      setc(c);
      wt(30);
      e = 6000.0;
      repeat (c) e = e * 1.003040572;
      check("exp", (sink_current >= e * 0.998 && sink_current <= e * 1.002), 32'h1);
    end
    bus(1'b1, bbc_pkg::IDX_CTRL, 8'h08);
    setc(11'd100);
    bus(1'b1, bbc_pkg::IDX_RAMP, 8'h20);
    s = 100;
    // Large rise then small fall, both over 400 cycles
    for (i = 0; i < 2; i++)
    begin
      c = (i == 0) ? 11'd2000 : 11'd1900;
      m = (s + c) / 2;
      setc(c);
      wt(200);
      bus(1'b0, bbc_pkg::IDX_STATUS, 8'h0);
      check("mid", (q[26:16] != c && q[26:16] > m - 150 && q[26:16] < m + 150), 32'h1);
      wt(300);
      code(c);
      s = c;
    end
    bus(1'b1, bbc_pkg::IDX_RAMP, 8'h00);
    setc(11'd1600);
    @(posedge clk) high_cnt <= 8'd77;
    wt(4300);
    code(11'd1600);
    bus(1'b1, bbc_pkg::IDX_CTRL, 8'h09);
    wt(4300);
    code(11'd481);
    check("duty_lin", sink_current, lin(11'd481));
    @(posedge clk) high_cnt <= 8'd0;
    wt(4300);
    check("no_duty", op_mode, 32'h1);
    bus(1'b1, bbc_pkg::IDX_RAMP, 8'h40);
    @(posedge clk) high_cnt <= 8'd77;
    wt(4300);
    code(11'd481);
    bus(1'b1, bbc_pkg::IDX_CTRL, 8'h0b);
    @(posedge clk) high_cnt <= 8'd200;
    wt(4300);
    bus(1'b0, bbc_pkg::IDX_STATUS, 8'h0);
    check("ramped", q[26:16] == 11'd1250, 32'h0);
    @(posedge clk) master_enable_n <= 1'b0;
    wt(3);
    check("shut", {op_mode, sink_current}, 32'h0);
    bus(1'b0, bbc_pkg::IDX_CTRL, 8'h0);
    check("shut_rd", q, 32'h0);
    @(posedge clk) master_enable_n <= 1'b1;
    wt(3);
    bus(1'b0, bbc_pkg::IDX_CTRL, 8'h0);
    check("restored", q, 32'h08);
    results();
  end
endmodule : testbench
